/* File: rtl/frf_pkg.sv */
package frf_pkg;
	// register layout
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [2:0] SYNC_RESET  = 3'h6;
	localparam int         RATE_LSB    = 0;
	localparam int         RATE_MSB    = 2;
	localparam int         RAMP_ON_BIT = 3;
	localparam int         SYNC_BIT    = 4;
	localparam int         FLOOR_LSB   = 5;
	localparam int         NUM_DRIVES  = 3;
	localparam logic [7:0] DUTY_ZERO   = 8'h00;

	// duty step per time slot, indexed by rate code
	localparam logic [7:0] RAMP_STEP [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
	                                         8'h08, 8'h0C, 8'h18, 8'h30};

	// slot time: slowest code covers 33..100 percent in 35 s
	localparam longint RAMP_SLOW_TIME_MS = 35000;
	localparam longint CLK_KHZ           = 40000;
	localparam longint RAMP_SPAN_STEPS   = 171;
	localparam int     SLOT_CYCLES_DFLT  =
		int'((RAMP_SLOW_TIME_MS * CLK_KHZ) / RAMP_SPAN_STEPS);
	localparam int     SLOT_W            = 24;

	// per drive inputs from the control loop
	typedef struct packed {
		logic [7:0] calcDuty;
		logic [7:0] minDuty;
		logic       belowStart;
	} frf_chan_s;

	// all state of the block
	typedef struct packed {
		logic [7:0]                 ctrl;
		logic [7:0]                 target1;
		logic [NUM_DRIVES-1:0][7:0] duty;
		logic [2:0]                 speedSync;
		logic [SLOT_W-1:0]          slotCnt;
	} frf_state_s;
endpackage : frf_pkg

/* File: rtl/frf_ramp_floor.sv */
`timescale 1ns/100ps
module frf_ramp_floor #(
	parameter int SLOT_CYCLES = frf_pkg::SLOT_CYCLES_DFLT
) (
	input  wire logic                                        clk_sys,
	input  wire logic                                        nrst,
	input  wire logic                                        wrEn,
	input  wire logic [7:0]                                  wrData,
	input  wire logic                                        cfgLock,
	input  wire logic                                        autoMode,
	input  wire logic                                        ctlUpdate,
	input  wire frf_pkg::frf_chan_s [frf_pkg::NUM_DRIVES-1:0] chanIn,
	output logic [7:0]                                       rdData,
	output logic [frf_pkg::NUM_DRIVES-1:0][7:0]              driveDuty,
	output logic [2:0]                                       speedSync
);
	frf_pkg::frf_state_s st;
	frf_pkg::frf_state_s next_st;
	logic [frf_pkg::NUM_DRIVES-1:0][7:0] floorDuty;
	logic [7:0]                          step;
	logic                                rampOn;
	logic                                slotTick;
	logic [8:0]                          gap;

	// floor selection below start temperature, per drive
	genvar g;
	generate
		for (g = 0; g < frf_pkg::NUM_DRIVES; g++) begin : gFloor
			always_comb begin
				if (autoMode && chanIn[g].belowStart) begin
					floorDuty[g] = st.ctrl[frf_pkg::FLOOR_LSB+g] ?
						chanIn[g].minDuty : frf_pkg::DUTY_ZERO;
				end else begin
					floorDuty[g] = chanIn[g].calcDuty;
				end
			end
		end
	endgenerate

	// ramp controls decoded from the register, slot tick from the slot counter
	assign step     = frf_pkg::RAMP_STEP[st.ctrl[frf_pkg::RATE_MSB:frf_pkg::RATE_LSB]];
	assign rampOn   = st.ctrl[frf_pkg::RAMP_ON_BIT];
	assign slotTick = (st.slotCnt == frf_pkg::SLOT_W'(SLOT_CYCLES - 1));

	// next state
	always_comb begin
		next_st = st;
		gap     = 9'h000;
		if (wrEn && !cfgLock) begin
			next_st.ctrl = wrData;
		end
		next_st.speedSync = {frf_pkg::SYNC_RESET[2:1], st.ctrl[frf_pkg::SYNC_BIT]};
		next_st.slotCnt = slotTick ? '0 : st.slotCnt + frf_pkg::SLOT_W'(1);
		if (ctlUpdate) begin
			next_st.target1 = floorDuty[0];
			next_st.duty[1] = floorDuty[1];
			next_st.duty[2] = floorDuty[2];
			if (!rampOn) begin
				next_st.duty[0] = floorDuty[0];
			end
		end
		// step drive 1 once per slot toward its target
		if (rampOn && slotTick) begin
			if (st.duty[0] < st.target1) begin
				gap = {1'b0, st.target1} - {1'b0, st.duty[0]};
				next_st.duty[0] = (gap > {1'b0, step}) ? st.duty[0] + step : st.target1;
			end else if (st.duty[0] > st.target1) begin
				gap = {1'b0, st.duty[0]} - {1'b0, st.target1};
				next_st.duty[0] = (gap > {1'b0, step}) ? st.duty[0] - step : st.target1;
			end
		end
	end

	// state register
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st         <= '0;
			st.ctrl    <= frf_pkg::CTRL_RESET;
			st.speedSync <= frf_pkg::SYNC_RESET;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from flops
	assign rdData    = st.ctrl;
	assign driveDuty = st.duty;
	assign speedSync = st.speedSync;

	// register at reset value on the first edge after release
	property p_reset_ctrl;
		@(posedge clk_sys)
		$rose(nrst) |-> (rdData == frf_pkg::CTRL_RESET);
	endproperty
	a_reset_ctrl: assert property (p_reset_ctrl) else $error("register not at reset value after reset");

	// all drives idle on the first edge after release
	property p_reset_duty;
		@(posedge clk_sys)
		$rose(nrst) |-> (driveDuty == '0);
	endproperty
	a_reset_duty: assert property (p_reset_duty) else $error("drive duty not zero after reset");

	// speed sync mask at reset value after release
	property p_reset_sync;
		@(posedge clk_sys)
		$rose(nrst) |-> (speedSync == frf_pkg::SYNC_RESET);
	endproperty
	a_reset_sync: assert property (p_reset_sync) else $error("speed sync mask wrong after reset");

	// lock freezes the register contents
	property p_lock_holds;
		@(posedge clk_sys) disable iff (!nrst)
		cfgLock |=> $stable(st.ctrl);
	endproperty
	a_lock_holds: assert property (p_lock_holds) else $error("locked register changed");

	// locked write leaves the read value alone
	property p_locked_out;
		@(posedge clk_sys) disable iff (!nrst)
		(wrEn && cfgLock) |=> $stable(rdData);
	endproperty
	a_locked_out: assert property (p_locked_out) else $error("locked write reached read data");

	// unlocked write lands one cycle later
	property p_write_takes;
		@(posedge clk_sys) disable iff (!nrst)
		(wrEn && !cfgLock) |=> (rdData == $past(wrData));
	endproperty
	a_write_takes: assert property (p_write_takes) else $error("unlocked write lost");

	// no write, no change
	property p_hold_idle;
		@(posedge clk_sys) disable iff (!nrst)
		!wrEn |=> $stable(rdData);
	endproperty
	a_hold_idle: assert property (p_hold_idle) else $error("register changed without write");

	// rate field picks the step size
	property p_rate_field;
		@(posedge clk_sys) disable iff (!nrst)
		(wrEn && !cfgLock)
		|=> (step == frf_pkg::RAMP_STEP[$past(wrData[frf_pkg::RATE_MSB:frf_pkg::RATE_LSB])]);
	endproperty
	a_rate_field: assert property (p_rate_field) else $error("ramp step does not follow rate field");

	// ramp enable follows its bit
	property p_ramp_on_bit;
		@(posedge clk_sys) disable iff (!nrst)
		(wrEn && !cfgLock) |=> (rampOn == $past(wrData[frf_pkg::RAMP_ON_BIT]));
	endproperty
	a_ramp_on_bit: assert property (p_ramp_on_bit) else $error("ramp enable does not follow its bit");

	// sync mask follows the sync bit
	property p_sync_map;
		@(posedge clk_sys) disable iff (!nrst)
		##1 (speedSync == {2'h3, $past(st.ctrl[frf_pkg::SYNC_BIT])});
	endproperty
	a_sync_map: assert property (p_sync_map) else $error("speed sync mask wrong");

	// sync bit clear leaves input 2 out
	property p_sync_off;
		@(posedge clk_sys) disable iff (!nrst)
		!st.ctrl[frf_pkg::SYNC_BIT] |=> (speedSync == frf_pkg::SYNC_RESET);
	endproperty
	a_sync_off: assert property (p_sync_off) else $error("input 2 synced while off");

	// sync bit set takes all three inputs
	property p_sync_on;
		@(posedge clk_sys) disable iff (!nrst)
		st.ctrl[frf_pkg::SYNC_BIT] |=> (speedSync == 3'h7);
	endproperty
	a_sync_on: assert property (p_sync_on) else $error("inputs 2 to 4 not synced");

	// inputs 3 and 4 always synced
	property p_sync_fixed;
		@(posedge clk_sys) disable iff (!nrst)
		speedSync[2:1] == 2'h3;
	endproperty
	a_sync_fixed: assert property (p_sync_fixed) else $error("inputs 3 and 4 not synced");

	// drive 1 off below start when floor bit clear
	property p_floor1;
		@(posedge clk_sys) disable iff (!nrst)
		(ctlUpdate && autoMode && chanIn[0].belowStart && !rampOn
		 && !st.ctrl[frf_pkg::FLOOR_LSB]) |=> (driveDuty[0] == 8'h00);
	endproperty
	a_floor1: assert property (p_floor1) else $error("drive 1 not off below start");

	// drive 1 at minimum below start when floor bit set
	property p_floor1_min;
		@(posedge clk_sys) disable iff (!nrst)
		(ctlUpdate && autoMode && chanIn[0].belowStart && !rampOn
		 && st.ctrl[frf_pkg::FLOOR_LSB]) |=> (driveDuty[0] == $past(chanIn[0].minDuty));
	endproperty
	a_floor1_min: assert property (p_floor1_min) else $error("drive 1 not at minimum below start");

	// drive 2 floor choice
	property p_floor2;
		@(posedge clk_sys) disable iff (!nrst)
		(ctlUpdate && autoMode && chanIn[1].belowStart)
		|=> (driveDuty[1] == ($past(st.ctrl[frf_pkg::FLOOR_LSB+1]) ? $past(chanIn[1].minDuty) : 8'h00));
	endproperty
	a_floor2: assert property (p_floor2) else $error("drive 2 floor wrong");

	// drive 3 floor choice
	property p_floor3;
		@(posedge clk_sys) disable iff (!nrst)
		(ctlUpdate && autoMode && chanIn[2].belowStart)
		|=> (driveDuty[2] == ($past(st.ctrl[frf_pkg::FLOOR_LSB+2]) ? $past(chanIn[2].minDuty) : 8'h00));
	endproperty
	a_floor3: assert property (p_floor3) else $error("drive 3 floor wrong");

	// drive 2 takes the loop duty above start
	property p_drive2_direct;
		@(posedge clk_sys) disable iff (!nrst)
		(ctlUpdate && !(autoMode && chanIn[1].belowStart))
		|=> (driveDuty[1] == $past(chanIn[1].calcDuty));
	endproperty
	a_drive2_direct: assert property (p_drive2_direct) else $error("drive 2 lost loop duty");

	// drive 3 takes the loop duty above start
	property p_drive3_direct;
		@(posedge clk_sys) disable iff (!nrst)
		(ctlUpdate && !(autoMode && chanIn[2].belowStart))
		|=> (driveDuty[2] == $past(chanIn[2].calcDuty));
	endproperty
	a_drive3_direct: assert property (p_drive3_direct) else $error("drive 3 lost loop duty");

	// ramp off: drive 1 jumps at the update
	property p_direct;
		@(posedge clk_sys) disable iff (!nrst)
		(ctlUpdate && !rampOn) |=> (driveDuty[0] == $past(floorDuty[0]));
	endproperty
	a_direct: assert property (p_direct) else $error("drive 1 did not jump");

	// every update records the drive 1 target
	property p_target_latch;
		@(posedge clk_sys) disable iff (!nrst)
		ctlUpdate |=> (st.target1 == $past(floorDuty[0]));
	endproperty
	a_target_latch: assert property (p_target_latch) else $error("drive 1 target not latched");

	// one slot never moves drive 1 more than a step
	property p_step_bound;
		@(posedge clk_sys) disable iff (!nrst)
		(rampOn && slotTick) |=> (((driveDuty[0] >= $past(driveDuty[0])) ? (driveDuty[0] - $past(driveDuty[0]))
			: ($past(driveDuty[0]) - driveDuty[0])) <= $past(step));
	endproperty
	a_step_bound: assert property (p_step_bound) else $error("ramp step too large");

	// below target: slot moves drive 1 up
	property p_step_up;
		@(posedge clk_sys) disable iff (!nrst)
		(rampOn && slotTick && (st.duty[0] < st.target1)) |=> (driveDuty[0] > $past(driveDuty[0]));
	endproperty
	a_step_up: assert property (p_step_up) else $error("drive 1 did not ramp up");

	// above target: slot moves drive 1 down
	property p_step_down;
		@(posedge clk_sys) disable iff (!nrst)
		(rampOn && slotTick && (st.duty[0] > st.target1)) |=> (driveDuty[0] < $past(driveDuty[0]));
	endproperty
	a_step_down: assert property (p_step_down) else $error("drive 1 did not ramp down");

	// upward ramp stops at the target
	property p_no_over_up;
		@(posedge clk_sys) disable iff (!nrst)
		(rampOn && slotTick && (st.duty[0] < st.target1)) |=> (driveDuty[0] <= $past(st.target1));
	endproperty
	a_no_over_up: assert property (p_no_over_up) else $error("drive 1 overshot target");

	// downward ramp stops at the target
	property p_no_over_down;
		@(posedge clk_sys) disable iff (!nrst)
		(rampOn && slotTick && (st.duty[0] > st.target1)) |=> (driveDuty[0] >= $past(st.target1));
	endproperty
	a_no_over_down: assert property (p_no_over_down) else $error("drive 1 undershot target");

	// far below target: exactly one full step up
	property p_full_step;
		@(posedge clk_sys) disable iff (!nrst)
		(rampOn && slotTick && (st.duty[0] < st.target1) && ((st.target1 - st.duty[0]) > step))
		|=> (driveDuty[0] == 8'($past(driveDuty[0]) + $past(step)));
	endproperty
	a_full_step: assert property (p_full_step) else $error("drive 1 step size wrong");

	// on target: drive 1 rests
	property p_at_target;
		@(posedge clk_sys) disable iff (!nrst)
		(rampOn && (st.duty[0] == st.target1)) |=> $stable(driveDuty[0]);
	endproperty
	a_at_target: assert property (p_at_target) else $error("drive 1 moved at target");

	// between slots drive 1 holds
	property p_slot_only;
		@(posedge clk_sys) disable iff (!nrst)
		(rampOn && !slotTick) |=> $stable(driveDuty[0]);
	endproperty
	a_slot_only: assert property (p_slot_only) else $error("drive 1 moved between slots");

	// slot counter wraps on the tick
	property p_slot_wrap;
		@(posedge clk_sys) disable iff (!nrst)
		slotTick |=> (st.slotCnt == '0);
	endproperty
	a_slot_wrap: assert property (p_slot_wrap) else $error("slot counter did not wrap");

	// slot counter counts by one between ticks
	property p_slot_count;
		@(posedge clk_sys) disable iff (!nrst)
		!slotTick |=> (st.slotCnt == $past(st.slotCnt) + frf_pkg::SLOT_W'(1));
	endproperty
	a_slot_count: assert property (p_slot_count) else $error("slot counter skipped");

	// main scenarios reached
	c_locked_write: cover property (@(posedge clk_sys) disable iff (!nrst) wrEn && cfgLock);
	c_ramp_up:      cover property (@(posedge clk_sys) disable iff (!nrst)
		rampOn && slotTick && (st.duty[0] < st.target1));
	c_ramp_down:    cover property (@(posedge clk_sys) disable iff (!nrst)
		rampOn && slotTick && (st.duty[0] > st.target1));
	c_floor_zero:   cover property (@(posedge clk_sys) disable iff (!nrst)
		ctlUpdate && autoMode && chanIn[2].belowStart && !st.ctrl[frf_pkg::FLOOR_LSB+2]);
	c_ramp_reach:   cover property (@(posedge clk_sys) disable iff (!nrst)
		rampOn && (st.duty[0] == st.target1) && (st.target1 != 8'h00));
endmodule : frf_ramp_floor

/* File: testbench/frf_fan_model.sv */
`timescale 1ns/100ps
// fans on the three drive outputs; speed settles on the applied duty
module frf_fan_model (
	input  wire logic            clk_sys,
	input  wire logic [2:0][7:0] driveDuty,
	output logic      [2:0][7:0] fanSpeed
);
	// one cycle of mechanical lag
	always_ff @(posedge clk_sys) begin
		fanSpeed <= driveDuty;
	end
endmodule : frf_fan_model

/* File: testbench/tb.sv */
`timescale 1ns/100ps
module tb;
	logic                     clk_sys = 0;
	logic                     nrst = 0;
	logic                     wrEn = 0;
	logic [7:0]               wrData = 0;
	logic                     cfgLock = 0;
	logic                     autoMode = 0;
	logic                     ctlUpdate = 0;
	frf_pkg::frf_chan_s [2:0] chanIn = '0;
	logic [7:0]               rdData;
	logic [2:0][7:0]          driveDuty;
	logic [2:0][7:0]          fanSpeed;
	logic [2:0]               speedSync;
	logic [7:0]               steps [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h30};
	int                       errors = 0;
	int                       checked = 0;
	int                       w;
	// 40 MHz clock
	always #12.5 clk_sys = ~clk_sys;
	frf_ramp_floor #(.SLOT_CYCLES(4)) frf_ramp_floor_inst (.clk_sys(clk_sys), .nrst(nrst), .wrEn(wrEn),
		.wrData(wrData), .cfgLock(cfgLock), .autoMode(autoMode), .ctlUpdate(ctlUpdate), .chanIn(chanIn),
		.rdData(rdData), .driveDuty(driveDuty), .speedSync(speedSync));
	frf_fan_model frf_fan_model_inst (.clk_sys(clk_sys), .driveDuty(driveDuty), .fanSpeed(fanSpeed));
	// compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one register write, result settled on return
	task automatic wr(input logic [7:0] d);
		@(negedge clk_sys);
		wrEn = 1;
		wrData = d;
		@(negedge clk_sys);
		wrEn = 0;
		@(negedge clk_sys);
	endtask : wr
	// one control update, same inputs on all drives
	task automatic upd(input logic [7:0] c, input logic [7:0] m, input logic b);
		@(negedge clk_sys);
		for (int i = 0; i < 3; i++) begin
			chanIn[i] = '{c, m, b};
		end
		ctlUpdate = 1;
		@(negedge clk_sys);
		ctlUpdate = 0;
	endtask : upd
	task automatic results;
		if (errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results
	// watchdog
	initial begin
		#200000;
		errors++;
		results();
	end
	// main sequence
	initial begin
		repeat (12) @(negedge clk_sys);
		nrst = 1;
		chk(rdData, 8'h00);
		chk({5'h00, speedSync}, 8'h06);
		wr(8'h10);
		chk({5'h00, speedSync}, 8'h07);
		upd(8'h5A, 8'h40, 1'b0);
		chk(driveDuty[0], 8'h5A);
		autoMode = 1;
		for (int k = 0; k < 2; k++) begin
			wr(k ? 8'h40 : 8'hA0);
			upd(8'h77, 8'h40, 1'b1);
			chk(driveDuty[0], k ? 8'h00 : 8'h40);
			chk(driveDuty[1], k ? 8'h40 : 8'h00);
			chk(driveDuty[2], k ? 8'h00 : 8'h40);
		end
		@(negedge clk_sys);
		chk(fanSpeed[1], 8'h40);
		autoMode = 0;
		cfgLock = 1;
		wr(8'hFF);
		chk(rdData, 8'h40);
		cfgLock = 0;
		// ramp from zero, first slot step per rate code
		for (int k = 0; k < 8; k++) begin
			wr({5'h00, k[2:0]});
			upd(8'h00, 8'h00, 1'b0);
			wr({5'h01, k[2:0]});
			upd(8'hC8, 8'h00, 1'b0);
			chk(driveDuty[1], 8'hC8);
			chk(driveDuty[0], 8'h00);
			w = 0;
			while (driveDuty[0] === 8'h00 && w < 20) begin
				@(negedge clk_sys);
				w++;
			end
			chk(driveDuty[0], steps[k]);
		end
		// finish the fast ramp, then ramp back down
		w = 0;
		while (driveDuty[0] !== 8'hC8 && w < 40) begin
			@(negedge clk_sys);
			w++;
		end
		chk(driveDuty[0], 8'hC8);
		upd(8'h10, 8'h00, 1'b0);
		chk(driveDuty[0], 8'hC8);
		w = 0;
		while (driveDuty[0] === 8'hC8 && w < 20) begin
			@(negedge clk_sys);
			w++;
		end
		chk(driveDuty[0], 8'h98);
		// second reset in mid run
		nrst = 0;
		repeat (2) @(negedge clk_sys);
		nrst = 1;
		chk(rdData, 8'h00);
		chk(driveDuty[0], 8'h00);
		chk({5'h00, speedSync}, 8'h06);
		results();
	end
endmodule : tb
